// >>> rtl/ir_bridge_core.sv
// Summary of operation
// RULE_01: one configuration, one interface, two 64-byte bulk endpoints.
// RULE_02: configuration only as vendor requests on the control endpoint.
// RULE_03: write: setup holds index and value; updates one 16-bit register.
// RULE_04: read: setup names index, data stage returns that 16-bit word.
// RULE_05: transmit: usb fills buffer, modulator drains; receive the reverse.
// RULE_06: mode bit 0 high selects fast infrared; low uses baud code.
// RULE_07: mode bit 1 selects fixed 1.6 us pulse, else 3/16 of bit time.
// RULE_08: mode bit 2 allows back-to-back frames; ignored in slow infrared.
// RULE_09: mode bit 4 picks odd or even parity; bit 3 is reserved.
// RULE_10: mode bits 7:5 hold baud code, reset value 1.
// RULE_11: software resets infrared logic after changing flagged mode fields.
// RULE_12: mode bit 8, reset 1, enables pll power-down.
// RULE_13: mode bit 9 resets 0; software sets it to open other registers.
// RULE_14: mode bit 10, reset 1, enables automatic direction choice.
// RULE_15: mode bit 11 picks transmit or receive when automatic direction off.
// RULE_16: read-only mode bit 14 shows whether a direction change is allowed.
// RULE_17: software polls bit 14 high before writing the direction bit.
// RULE_18: mode bit 12, reset 1, enables automatic interaction pulses.
// RULE_19: each 0-to-1 change of mode bit 13 emits one interaction pulse.
// RULE_20: pulse high and low times are programmable 48 MHz counts.
// RULE_21: writing 0 to mode bit 15 resets datapath; bit returns to 1.
// RULE_22: automatic direction transmits when data queued and receiver idle.
// RULE_23: master reset restores all mode defaults and empties the buffer.
`default_nettype none
module ir_bridge_core (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire ir_bridge_pkg::setup_req_t setup,
	output var ir_bridge_pkg::reply_t    reply,
	input  wire logic                    usb_out_valid,
	input  wire logic [7:0]              usb_out_data,
	output logic                         usb_out_ready,
	output logic                         usb_in_valid,
	output logic [7:0]                   usb_in_data,
	output logic                         usb_in_last,
	input  wire logic                    usb_in_ready,
	output logic                         ir_tx_valid,
	output logic [7:0]                   ir_tx_data,
	input  wire logic                    ir_tx_ready,
	input  wire logic                    ir_rx_valid,
	input  wire logic [7:0]              ir_rx_data,
	output logic                         ir_rx_ready,
	input  wire logic                    ir_rx_active,
	output var ir_bridge_pkg::ir_cfg_t   ir_cfg,
	output logic                         sip_pulse,
	output logic                         ir_reset
);
	import ir_bridge_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic [1:0] rst_pipe;
	logic       rst_q_n;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_q_n = rst_pipe[1];

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// 48 MHz counts to local cycles, rounded up, never below one
	function automatic logic [10:0] pulse_cycles(input logic [8:0] n);
		int c;
		c = (int'(n) * CLK_MHZ + PULSE_REF_MHZ - 1) / PULSE_REF_MHZ;
		if (c < 1)
			c = 1;
		return c[10:0];
	endfunction

	function automatic logic is_slow(input logic [15:0] m);
		return !m[FAST_BIT] && (m[BAUD_MSB:BAUD_LSB] < SLOW_BAUD_LIMIT);
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	core_state_t st_reg;
	core_state_t st_next;
	logic        permit;
	logic [15:0] mode_view;
	logic        push;
	logic        pop;
	logic        pulse_req;

	assign permit = (st_reg.count == 2'd0) && (st_reg.p_state == P_IDLE);

	always_comb
	begin
		st_next = st_reg;
		st_next.reply.valid = 1'b0;
		st_next.soft_rst = 1'b0;
		pulse_req = 1'b0;
		mode_view = st_reg.mode;
		mode_view[PERMIT_BIT] = permit; // [RULE_16]
		mode_view[3] = 1'b0; // [RULE_09]

		// pin level; first stage feeds only the second
		st_next.rx_sync = {st_reg.rx_sync[1:0], ir_rx_active};
		if (st_reg.rx_sync[2] == st_reg.rx_sync[1])
			st_next.rx_active = st_reg.rx_sync[2];

		// vendor requests on the control endpoint
		if (setup.valid) // [RULE_02]
		begin
			st_next.reply.valid = 1'b1;
			st_next.reply.data = 16'h0000;
			if (setup.is_read) // [RULE_04]
			begin
				case (setup.index)
					MODE_IDX:  st_next.reply.data = mode_view;
					PULSE_IDX: st_next.reply.data = st_reg.pulse;
					default:   st_next.reply.data = 16'h0000;
				endcase
			end
			else if (setup.index == MODE_IDX) // [RULE_03]
			begin
				st_next.mode = (setup.value & MODE_WMASK) | MODE_FORCE; // [RULE_21]
				st_next.soft_rst = !setup.value[SOFT_RST_BIT]; // [RULE_21]
				pulse_req = setup.value[TRIGGER_BIT]
					&& !st_reg.mode[TRIGGER_BIT]; // [RULE_19]
			end
			// gated until the driver bit is set
			else if (setup.index == PULSE_IDX && st_reg.mode[DRIVER_BIT])
				st_next.pulse = setup.value; // [RULE_13] [RULE_20]
		end

		// two-entry buffer, shared by both directions
		push = st_reg.tx_dir ? (usb_out_valid && st_reg.usb_out_ready)
			: (ir_rx_valid && st_reg.ir_rx_ready); // [RULE_05]
		pop = st_reg.tx_dir ? (st_reg.ir_tx_valid && ir_tx_ready)
			: (st_reg.usb_in_valid && usb_in_ready); // [RULE_05]
		if (push)
		begin
			st_next.mem[st_reg.wr_ptr] = st_reg.tx_dir ? usb_out_data
				: ir_rx_data;
			st_next.wr_ptr = !st_reg.wr_ptr;
		end
		if (pop)
			st_next.rd_ptr = !st_reg.rd_ptr;
		st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
		if (pop && !st_reg.tx_dir) // [RULE_01]
		begin
			if (st_reg.usb_in_last)
				st_next.pkt_cnt = 6'h00;
			else
				st_next.pkt_cnt = st_reg.pkt_cnt + 6'h01;
		end

		// direction turns only with the buffer empty, or to receive on a soft reset
		if (st_reg.count == 2'd0)
		begin
			if (st_reg.mode[AUTO_DIR_BIT]) // [RULE_14]
				st_next.tx_dir = usb_out_valid && !st_reg.rx_active; // [RULE_22]
			else
				st_next.tx_dir = st_reg.mode[DIR_BIT]; // [RULE_15]
		end
		if (st_next.tx_dir && !st_reg.tx_dir && st_reg.mode[AUTO_PULSE_BIT])
			pulse_req = 1'b1; // [RULE_18]

		// interaction pulse generator
		case (st_reg.p_state)
			P_IDLE:
			begin
				if (pulse_req || st_reg.p_pending)
				begin
					st_next.p_state = P_HIGH;
					st_next.p_cnt = pulse_cycles({2'b00,
						st_reg.pulse[HIGH_MSB:HIGH_LSB]}) - 11'd1; // [RULE_20]
					// a second request in the same cycle is kept
					st_next.p_pending = pulse_req && st_reg.p_pending;
				end
			end
			P_HIGH:
			begin
				if (pulse_req)
					st_next.p_pending = 1'b1;
				if (st_reg.p_cnt == 11'd0)
				begin
					st_next.p_state = P_LOW;
					st_next.p_cnt = pulse_cycles(
						st_reg.pulse[LOW_MSB:LOW_LSB]) - 11'd1; // [RULE_20]
				end
				else
					st_next.p_cnt = st_reg.p_cnt - 11'd1;
			end
			P_LOW:
			begin
				if (pulse_req)
					st_next.p_pending = 1'b1;
				if (st_reg.p_cnt == 11'd0)
					st_next.p_state = P_IDLE;
				else
					st_next.p_cnt = st_reg.p_cnt - 11'd1;
			end
			default:
			begin
				st_next.p_state = P_IDLE;
				st_next.p_cnt = 11'd0;
			end
		endcase

		// soft reset clears the datapath, not the registers
		if (st_reg.soft_rst) // [RULE_21]
		begin
			st_next.count = 2'd0;
			st_next.wr_ptr = 1'b0;
			st_next.rd_ptr = 1'b0;
			st_next.pkt_cnt = 6'h00;
			st_next.tx_dir = 1'b0;
			st_next.p_state = P_IDLE;
			st_next.p_cnt = 11'd0;
			st_next.p_pending = 1'b0;
		end

		// registered outputs, taken from the next state
		st_next.usb_out_ready = st_next.tx_dir && (st_next.count != 2'd2);
		st_next.ir_rx_ready = !st_next.tx_dir && (st_next.count != 2'd2);
		st_next.ir_tx_valid = st_next.tx_dir && (st_next.count != 2'd0);
		st_next.usb_in_valid = !st_next.tx_dir && (st_next.count != 2'd0);
		st_next.ir_tx_data = st_next.mem[st_next.rd_ptr];
		st_next.usb_in_data = st_next.mem[st_next.rd_ptr];
		st_next.usb_in_last = st_next.usb_in_valid
			&& (st_next.pkt_cnt == PKT_LAST_CNT
			|| st_next.count == 2'd1); // [RULE_01]
		st_next.pulse_out = (st_next.p_state == P_HIGH);
		st_next.cfg.fast_infrared_select = st_next.mode[FAST_BIT]; // [RULE_06]
		st_next.cfg.fixed_pulse_width_select =
			st_next.mode[FIXED_PW_BIT]; // [RULE_07]
		st_next.cfg.slow_mode = is_slow(st_next.mode); // [RULE_06]
		st_next.cfg.back_to_back_tx_enable = st_next.mode[B2B_BIT]
			&& !is_slow(st_next.mode); // [RULE_08]
		st_next.cfg.parity_odd = st_next.mode[PARITY_BIT]; // [RULE_09]
		st_next.cfg.baud_code = st_next.mode[BAUD_MSB:BAUD_LSB]; // [RULE_10]
		st_next.cfg.pll_powerdown_enable = st_next.mode[PLL_BIT]; // [RULE_12]
		st_next.cfg.tx_direction = st_next.tx_dir;
	end

	always_ff @(posedge ref_clk or negedge rst_q_n)
	begin
		if (!rst_q_n) // [RULE_23]
		begin
			st_reg <= '0;
			st_reg.mode <= MODE_RESET;
			st_reg.pulse <= PULSE_RESET;
			st_reg.p_state <= P_IDLE;
			st_reg.ir_rx_ready <= 1'b1;
			st_reg.cfg.back_to_back_tx_enable <= 1'b0; // [RULE_08]
			st_reg.cfg.baud_code <= MODE_RESET[BAUD_MSB:BAUD_LSB];
			st_reg.cfg.slow_mode <= 1'b1;
			st_reg.cfg.pll_powerdown_enable <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	assign reply = st_reg.reply;
	assign usb_out_ready = st_reg.usb_out_ready;
	assign usb_in_valid = st_reg.usb_in_valid;
	assign usb_in_data = st_reg.usb_in_data;
	assign usb_in_last = st_reg.usb_in_last;
	assign ir_tx_valid = st_reg.ir_tx_valid;
	assign ir_tx_data = st_reg.ir_tx_data;
	assign ir_rx_ready = st_reg.ir_rx_ready;
	assign ir_cfg = st_reg.cfg;
	assign sip_pulse = st_reg.pulse_out;
	assign ir_reset = st_reg.soft_rst;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_q_n);

	sequence mode_write_s;
		setup.valid && !setup.is_read && setup.index == MODE_IDX;
	endsequence

	sequence trigger_rise_s;
		mode_write_s ##0 (setup.value[TRIGGER_BIT]
			&& !st_reg.mode[TRIGGER_BIT] && st_reg.p_state == P_IDLE
			&& !st_reg.soft_rst && setup.value[SOFT_RST_BIT]);
	endsequence

	reply_timing_a: assert property ( // [RULE_03]
		setup.valid |=> reply.valid ##1 !reply.valid || $past(setup.valid))
		else $error("request not answered in one cycle");

	read_pulse_reg_a: assert property ( // [RULE_04]
		setup.valid && setup.is_read && setup.index == PULSE_IDX
		|=> reply.data == $past(st_reg.pulse))
		else $error("read word returned wrong value");

	soft_reset_a: assert property ( // [RULE_21]
		mode_write_s ##0 !setup.value[SOFT_RST_BIT]
		|=> ir_reset ##1 (st_reg.mode[SOFT_RST_BIT] && !ir_reset
			&& st_reg.count == 2'd0))
		else $error("soft reset did not pulse and self-restore");

	trigger_pulse_a: assert property ( // [RULE_19]
		trigger_rise_s |=> ##1 sip_pulse)
		else $error("trigger rise gave no pulse");

	pulse_high_len_a: assert property ( // [RULE_20]
		$rose(sip_pulse) |-> st_reg.p_cnt
		== pulse_cycles({2'b00, st_reg.pulse[HIGH_MSB:HIGH_LSB]}) - 11'd1)
		else $error("pulse high time wrong");

	slow_b2b_a: assert property ( // [RULE_08]
		ir_cfg.slow_mode |-> !ir_cfg.back_to_back_tx_enable)
		else $error("back-to-back active in slow infrared");

	manual_dir_a: assert property ( // [RULE_15]
		!st_reg.mode[AUTO_DIR_BIT] && st_reg.count == 2'd0
		&& !st_reg.soft_rst |=> ir_cfg.tx_direction == $past(st_reg.mode[DIR_BIT]))
		else $error("manual direction not followed");

	driver_gate_a: assert property ( // [RULE_13]
		setup.valid && !setup.is_read && setup.index == PULSE_IDX
		&& !st_reg.mode[DRIVER_BIT] |=> $stable(st_reg.pulse))
		else $error("register written before driver bit set");

	buffer_bound_a: assert property ( // [RULE_05]
		st_reg.count <= 2'd2 && !(usb_out_ready && ir_rx_ready))
		else $error("buffer overflow or both sources open");

	permit_read_a: assert property ( // [RULE_16]
		setup.valid && setup.is_read && setup.index == MODE_IDX
		|=> reply.data[PERMIT_BIT] == $past(permit))
		else $error("permit status misreported");
endmodule
`default_nettype wire

// >>> shared/ir_bridge_pkg.sv
`default_nettype none
package ir_bridge_pkg;
	// ------------------------------------------------------------
	// sizes, register map, timing
	// ------------------------------------------------------------
	localparam int DATA_W          = 8;
	localparam int BUF_DEPTH       = 2;
	localparam int BULK_EP_COUNT   = 2;
	localparam int BULK_MAX_PACKET = 64;
	localparam logic [15:0] MODE_IDX    = 16'h0000;
	localparam logic [15:0] PULSE_IDX   = 16'h0003;
	localparam logic [15:0] MODE_RESET  = 16'hD524;
	localparam logic [15:0] MODE_WMASK  = 16'h3FF7;
	localparam logic [15:0] MODE_FORCE  = 16'h8000;
	localparam logic [15:0] PULSE_RESET = 16'hAA4C;
	localparam int FAST_BIT       = 0;
	localparam int FIXED_PW_BIT   = 1;
	localparam int B2B_BIT        = 2;
	localparam int PARITY_BIT     = 4;
	localparam int BAUD_LSB       = 5;
	localparam int BAUD_MSB       = 7;
	localparam int PLL_BIT        = 8;
	localparam int DRIVER_BIT     = 9;
	localparam int AUTO_DIR_BIT   = 10;
	localparam int DIR_BIT        = 11;
	localparam int AUTO_PULSE_BIT = 12;
	localparam int TRIGGER_BIT    = 13;
	localparam int PERMIT_BIT     = 14;
	localparam int SOFT_RST_BIT   = 15;
	localparam int HIGH_LSB       = 0;
	localparam int HIGH_MSB       = 6;
	localparam int LOW_LSB        = 7;
	localparam int LOW_MSB        = 15;
	localparam logic [2:0] SLOW_BAUD_LIMIT = 3'h6;
	localparam logic [5:0] PKT_LAST_CNT    = 6'h3F;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CLK_MHZ        = 1000 / CLK_PERIOD_NS;
	localparam int PULSE_REF_MHZ  = 48;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		P_IDLE = 3'b001,
		P_HIGH = 3'b010,
		P_LOW  = 3'b100
	} pulse_state_t;

	typedef struct packed {
		logic        valid;
		logic        is_read;
		logic [15:0] index;
		logic [15:0] value;
	} setup_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} reply_t;

	typedef struct packed {
		logic       fast_infrared_select;
		logic       fixed_pulse_width_select;
		logic       back_to_back_tx_enable;
		logic       parity_odd;
		logic [2:0] baud_code;
		logic       slow_mode;
		logic       pll_powerdown_enable;
		logic       tx_direction;
	} ir_cfg_t;

	typedef struct packed {
		logic [15:0]               mode;
		logic [15:0]               pulse;
		logic                      soft_rst;
		logic                      tx_dir;
		logic [BUF_DEPTH-1:0][7:0] mem;
		logic                      wr_ptr;
		logic                      rd_ptr;
		logic [1:0]                count;
		logic [5:0]                pkt_cnt;
		pulse_state_t              p_state;
		logic [10:0]               p_cnt;
		logic                      p_pending;
		logic [2:0]                rx_sync;
		logic                      rx_active;
		reply_t                    reply;
		ir_cfg_t                   cfg;
		logic                      usb_out_ready;
		logic                      ir_rx_ready;
		logic                      usb_in_valid;
		logic [7:0]                usb_in_data;
		logic                      usb_in_last;
		logic                      ir_tx_valid;
		logic [7:0]                ir_tx_data;
		logic                      pulse_out;
	} core_state_t;
endpackage
`default_nettype wire

// >>> tb/ir_far_model.sv
`default_nettype none
module ir_far_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       stall,
	input  wire logic [3:0] rx_num,
	input  wire logic       ir_tx_valid,
	output logic            ir_tx_ready,
	output logic            ir_rx_valid,
	output logic [7:0]      ir_rx_data,
	input  wire logic       ir_rx_ready,
	output logic            ir_rx_active
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] sent;

	// ------------------------------------------------------------
	// modulator drains the buffer, stalling every other cycle
	// ------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			ir_tx_ready <= 1'b0;
		else
			ir_tx_ready <= stall ? ~ir_tx_ready : 1'b1;

	// ------------------------------------------------------------
	// demodulator fills the buffer, rx_num bytes in all
	// ------------------------------------------------------------
	always @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			sent <= 4'h0;
			ir_rx_valid <= 1'b0;
			ir_rx_data <= 8'h00;
		end
		else if (ir_rx_valid && ir_rx_ready)
		begin
			sent <= sent + 4'h1;
			ir_rx_valid <= 1'b0;
			// stale byte must not look valid
			ir_rx_data <= ~ir_rx_data;
		end
		else if (!ir_rx_valid && sent < rx_num)
		begin
			ir_rx_valid <= 1'b1;
			ir_rx_data <= 8'hA0 + {4'h0, sent};
		end

	// receiver busy for as long as bytes remain
	assign ir_rx_active = sent < rx_num;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ir_bridge_pkg::*;
	logic        ref_clk, rst_n, stall, sip_pulse, ir_reset, rst_seen;
	logic        usb_out_valid, usb_out_ready, usb_in_valid, usb_in_last;
	logic        usb_in_ready, ir_tx_valid, ir_tx_ready, ir_rx_valid;
	logic        ir_rx_ready, ir_rx_active;
	logic [7:0]  usb_out_data, usb_in_data, ir_tx_data, ir_rx_data;
	logic [3:0]  rx_num;
	logic [15:0] d;
	setup_req_t  setup;
	reply_t      reply;
	ir_cfg_t     ir_cfg;
	logic [7:0]  txq[$], rxq[$];
	int          fails, total_checks, cycles, hi_run, last_hi, pulses, base;
	int          last_cnt;

	ir_bridge_core DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .setup(setup), .reply(reply),
		.usb_out_valid(usb_out_valid), .usb_out_data(usb_out_data),
		.usb_out_ready(usb_out_ready), .usb_in_valid(usb_in_valid),
		.usb_in_data(usb_in_data), .usb_in_last(usb_in_last),
		.usb_in_ready(usb_in_ready), .ir_tx_valid(ir_tx_valid),
		.ir_tx_data(ir_tx_data), .ir_tx_ready(ir_tx_ready),
		.ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
		.ir_rx_ready(ir_rx_ready), .ir_rx_active(ir_rx_active),
		.ir_cfg(ir_cfg), .sip_pulse(sip_pulse), .ir_reset(ir_reset)
	);

	ir_far_model far (
		.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .rx_num(rx_num),
		.ir_tx_valid(ir_tx_valid), .ir_tx_ready(ir_tx_ready),
		.ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
		.ir_rx_ready(ir_rx_ready), .ir_rx_active(ir_rx_active)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic conclude;
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic access(input logic rd, input logic [15:0] idx,
		input logic [15:0] val);
		@(posedge ref_clk);
		setup <= '{valid:1'b1, is_read:rd, index:idx, value:val};
		@(posedge ref_clk);
		setup.valid <= 1'b0;
		#1;
		check({15'h0000, reply.valid}, 16'h0001);
		d = reply.data;
		rst_seen = ir_reset;
	endtask

	task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
		access(1'b1, idx, 16'h0000);
		check(d, exp);
	endtask

	task automatic push(input logic [7:0] b);
		int n;
		n = 0;
		usb_out_valid <= 1'b1;
		usb_out_data <= b;
		// hold the byte until an edge sees ready high
		do
			@(negedge ref_clk);
		while (!usb_out_ready && n++ < 200);
		@(posedge ref_clk);
	endtask

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge ref_clk);
	endtask

	// ------------------------------------------------------------
	// clock, sinks, monitors, watchdog
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		// usb side stalls every other cycle
		usb_in_ready <= ~usb_in_ready;
		if (ir_tx_valid && ir_tx_ready)
			txq.push_back(ir_tx_data);
		if (usb_in_valid && usb_in_ready)
		begin
			rxq.push_back(usb_in_data);
			last_cnt += int'(usb_in_last);
		end
		if (sip_pulse && hi_run == 0)
			pulses++;
		if (sip_pulse)
			hi_run++;
		else if (hi_run != 0)
		begin
			last_hi = hi_run;
			hi_run = 0;
		end
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		setup = '0;
		rst_n = 1'b0;
		stall = 1'b1;
		rx_num = 4'h0;
		usb_out_valid = 1'b0;
		usb_out_data = 8'h00;
		usb_in_ready = 1'b0;
		do_reset();
		rd(MODE_IDX, 16'hD524);
		check({6'h00, ir_cfg}, 16'h000E);
		access(1'b0, MODE_IDX, 16'hCAFF);
		repeat (4) @(posedge ref_clk);
		rd(MODE_IDX, 16'hCAF7);
		check({6'h00, ir_cfg}, 16'h03F9);
		access(1'b0, PULSE_IDX, 16'h0182);
		rd(PULSE_IDX, 16'h0182);
		base = pulses;
		access(1'b0, MODE_IDX, 16'hEAF9);
		rd(MODE_IDX, 16'hAAF1);
		repeat (40) @(posedge ref_clk);
		check(last_hi[15:0], 16'h0005);
		// bit already set: no second pulse
		access(1'b0, MODE_IDX, 16'hEAF9);
		repeat (40) @(posedge ref_clk);
		check(pulses[15:0] - base[15:0], 16'h0001);
		access(1'b0, MODE_IDX, 16'h6AF9);
		check({15'h0000, rst_seen}, 16'h0001);
		repeat (4) @(posedge ref_clk);
		rd(MODE_IDX, 16'hEAF1);
		access(1'b0, MODE_IDX, 16'hA8F9);
		access(1'b0, PULSE_IDX, 16'h0005);
		rd(PULSE_IDX, 16'h0182);
		rd(16'h0001, 16'h0000);
		rd(MODE_IDX, 16'hE8F1);
		access(1'b0, MODE_IDX, 16'hA0F9);
		rx_num <= 4'h4;
		repeat (300)
			if (rxq.size() < 4)
				@(posedge ref_clk);
		for (int i = 0; i < 4; i++)
			check({8'h00, rxq[i]}, 16'h00A0 + i[15:0]);
		// every byte empties the buffer, so each one closes its packet
		check(last_cnt[15:0], 16'h0004);
		base = pulses;
		access(1'b0, MODE_IDX, 16'h94F9);
		@(posedge ref_clk);
		push(8'h11);
		push(8'h22);
		push(8'h33);
		push(8'h44);
		usb_out_valid <= 1'b0;
		repeat (300)
			if (txq.size() < 4)
				@(posedge ref_clk);
		for (int i = 0; i < 4; i++)
			check({8'h00, txq[i]}, 16'h0011 * (i[15:0] + 1));
		check(pulses[15:0] - base[15:0], 16'h0001);
		// quiet receiver, or bytes would arrive right after reset
		rx_num <= 4'h0;
		do_reset();
		rd(MODE_IDX, 16'hD524);
		check({6'h00, ir_cfg}, 16'h000E);
		rd(PULSE_IDX, 16'hAA4C);
		conclude();
	end
endmodule
`default_nettype wire
